/* logic/odc_decoder.sv */
`timescale 1ns/1ps
module odc_decoder #(
    parameter int NUM_CH = odc_pkg::NUM_CH
) (
    input wire logic i_mclk,                    // 100 MHz clock
    input wire logic i_sys_rst,                 // sync reset, high
    input wire logic i_scl,                     // bus clock pin
    input wire logic i_sda,                     // bus data pin level
    output logic o_sda_oe,                      // pull data low while high
    output logic o_sda_out,                     // data drive value, always 0
    input wire logic i_two_strap,               // two-strap variant
    input wire logic [1:0] i_strap_pin_upper,   // upper strap level
    input wire logic [1:0] i_strap_pin_lower,   // lower strap level
    output logic [NUM_CH*16-1:0] o_out_regs,    // channel output registers
    output logic [15:0] o_power_ctrl,           // power control register
    output logic [15:0] o_clear_code,           // clear-code register
    output logic [15:0] o_load_mask,            // load-mask register
    output logic o_sw_reset                     // software reset pulse
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } odc_state_t;

    typedef struct packed {
        odc_state_t state;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic [1:0] byte_idx;
        logic rd;
        logic [7:0] command_access_byte;
        logic [7:0] high_data_byte;
        logic [6:0] my_addr;
        logic scl_d;
        logic sda_d;
        logic sda_oe;
        logic pend_update;
        logic sw_reset;
        logic [NUM_CH-1:0][15:0] in_regs;
        logic [NUM_CH-1:0][15:0] out_regs;
        logic [15:0] power_ctrl;
        logic [15:0] clear_code;
        logic [15:0] load_mask;
        logic [15:0] tx_word;
    } odc_regs_t;

    odc_regs_t r;
    odc_regs_t n;
    logic scl_s;
    logic sda_s;
    logic [2:0] strap_bits;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [3:0] cmd;
    logic [3:0] acc;
    logic [15:0] word;
    logic [NUM_CH-1:0] sel;
    logic [15:0] rd_word;
    logic two_strap_s;
    logic [1:0] strap_up_s;
    logic [1:0] strap_lo_s;

    ////////////////////////////////////////////////////////////////////////
    odc_sync #(.WIDTH(2)) u_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_rst_val(1'b1),
        .i_async({i_scl, i_sda}),
        .o_sync({scl_s, sda_s})
    );

    // straps are pins: two flops before decode
    odc_sync #(.WIDTH(5)) u_strap_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_rst_val(1'b0),
        .i_async({i_two_strap, i_strap_pin_upper, i_strap_pin_lower}),
        .o_sync({two_strap_s, strap_up_s, strap_lo_s})
    );

    odc_strap_decode u_strap (
        .i_two_strap(two_strap_s),
        .i_upper(strap_up_s),
        .i_lower(strap_lo_s),
        .o_low_bits(strap_bits)
    );

    ////////////////////////////////////////////////////////////////////////
    assign scl_rise = scl_s && !r.scl_d;
    assign scl_fall = !scl_s && r.scl_d;
    assign start_cond = scl_s && r.scl_d && r.sda_d && !sda_s;
    assign stop_cond = scl_s && r.scl_d && !r.sda_d && sda_s;
    assign cmd = r.command_access_byte[odc_pkg::CMD_MSB:odc_pkg::CMD_LSB];
    assign acc = r.command_access_byte[odc_pkg::ACC_MSB:odc_pkg::ACC_LSB];
    assign word = {r.high_data_byte, r.shreg};

    always_comb begin
        sel = '0;
        if (acc == odc_pkg::ACC_ALL) begin
            sel = '1;
        end else if (!acc[3]) begin
            sel[acc[2:0]] = 1'b1;
        end
    end

    // read data source
    always_comb begin
        rd_word = odc_pkg::REG_RESET;
        unique case (cmd)
            odc_pkg::CMD_WR_IN: rd_word = r.in_regs[acc[2:0]];
            odc_pkg::CMD_UPD_CH: rd_word = r.out_regs[acc[2:0]];
            odc_pkg::CMD_POWER: rd_word = r.power_ctrl;
            odc_pkg::CMD_CLEAR: rd_word = r.clear_code;
            odc_pkg::CMD_LOAD_MASK: rd_word = r.load_mask;
            default: rd_word = odc_pkg::REG_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        n.scl_d = scl_s;
        n.sda_d = sda_s;
        n.sw_reset = 1'b0;
        if (r.state == ST_IDLE) begin
            n.my_addr = {odc_pkg::ADDR_PREFIX, strap_bits};
        end
        if (start_cond) begin
            n.state = ST_RX;
            n.bitcnt = 4'h0;
            n.byte_idx = 2'h0;
            n.sda_oe = 1'b0;
        end else if (stop_cond) begin
            n.state = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.state)
                ST_IDLE, ST_IGNORE: begin
                    n.sda_oe = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        n.shreg = {r.shreg[6:0], sda_s};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end
                    if (scl_fall && r.bitcnt == 4'h8) begin
                        n.bitcnt = 4'h0;
                        n.state = ST_ACK;
                        n.sda_oe = 1'b1;
                        if (r.byte_idx == 2'h0) begin
                            // address match on prefix and straps
                            if (r.shreg[7:1] != r.my_addr) begin
                                n.state = ST_IGNORE;
                                n.sda_oe = 1'b0;
                            end
                            n.rd = r.shreg[0];
                            n.tx_word = rd_word;
                        end else if (r.byte_idx == 2'h1) begin
                            n.command_access_byte = r.shreg;
                        end else if (r.byte_idx == 2'h2) begin
                            n.high_data_byte = r.shreg;
                        end else begin
                            n.pend_update = 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.state = ST_RX;
                        if (r.byte_idx == 2'h0 && r.rd) begin
                            // read phase starts with high byte
                            n.state = ST_TX;
                            n.sda_oe = !r.tx_word[15];
                        end else if (r.byte_idx == 2'h3) begin
                            n.byte_idx = 2'h2;
                        end else begin
                            n.byte_idx = r.byte_idx + 2'h1;
                        end
                        // update at falling edge of last ack
                        if (r.pend_update) begin
                            n.pend_update = 1'b0;
                            unique case (cmd)
                                odc_pkg::CMD_WR_IN: begin
                                    for (int i = 0; i < NUM_CH; i++) begin
                                        if (sel[i]) n.in_regs[i] = word;
                                    end
                                end
                                odc_pkg::CMD_UPD_CH: begin
                                    for (int i = 0; i < NUM_CH; i++) begin
                                        if (sel[i]) n.out_regs[i] = r.in_regs[i];
                                    end
                                end
                                odc_pkg::CMD_WR_UPD_ALL: begin
                                    for (int i = 0; i < NUM_CH; i++) begin
                                        n.in_regs[i] = sel[i] ? word : r.in_regs[i];
                                        n.out_regs[i] = n.in_regs[i];
                                    end
                                end
                                odc_pkg::CMD_WR_UPD_CH: begin
                                    for (int i = 0; i < NUM_CH; i++) begin
                                        if (sel[i]) begin
                                            n.in_regs[i] = word;
                                            n.out_regs[i] = word;
                                        end
                                    end
                                end
                                odc_pkg::CMD_POWER: n.power_ctrl = word;
                                odc_pkg::CMD_CLEAR: n.clear_code = word;
                                odc_pkg::CMD_LOAD_MASK: n.load_mask = word;
                                odc_pkg::CMD_SW_RESET: begin
                                    n.sw_reset = 1'b1;
                                    n.in_regs = '0;
                                    n.out_regs = '0;
                                    n.power_ctrl = odc_pkg::REG_RESET;
                                    n.clear_code = odc_pkg::REG_RESET;
                                    n.load_mask = odc_pkg::REG_RESET;
                                end
                                default: n.sw_reset = 1'b0;
                            endcase
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        n.bitcnt = r.bitcnt + 4'h1;
                        n.tx_word = {r.tx_word[14:0], 1'b0};
                        if (r.bitcnt == 4'h7) begin
                            n.state = ST_TX_ACK;
                            n.sda_oe = 1'b0;
                            n.bitcnt = 4'h0;
                        end else begin
                            n.sda_oe = !r.tx_word[14];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        n.rd = !sda_s;
                    end
                    if (scl_fall) begin
                        n.state = r.rd ? ST_TX : ST_IGNORE;
                        n.sda_oe = r.rd && !r.tx_word[15];
                    end
                end
                default: n.state = ST_IDLE;
            endcase
        end
        if (i_sys_rst) begin
            n = '0;
            n.state = ST_IDLE;
            n.scl_d = 1'b1;
            n.sda_d = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        r <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            o_out_regs[i*16 +: 16] = r.out_regs[i];
        end
    end
    assign o_sda_oe = r.sda_oe;
    assign o_sda_out = 1'b0;
    assign o_power_ctrl = r.power_ctrl;
    assign o_clear_code = r.clear_code;
    assign o_load_mask = r.load_mask;
    assign o_sw_reset = r.sw_reset;

    ////////////////////////////////////////////////////////////////////////
    sequence s_ack_end;
        r.state == ST_ACK && scl_fall && r.pend_update;
    endsequence

    a_addr_nomatch: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (r.state == ST_RX && scl_fall && r.bitcnt == 4'h8 && r.byte_idx == 2'h0
         && r.shreg[7:4] != odc_pkg::ADDR_PREFIX) |=> r.state == ST_IGNORE && !r.sda_oe)
        else $error("bad prefix acknowledged");
    a_addr_idle_sample: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (r.state == ST_IDLE && !start_cond) |=> r.my_addr == {odc_pkg::ADDR_PREFIX, $past(strap_bits)})
        else $error("address not resampled");
    a_write_input: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (s_ack_end ##0 (cmd == odc_pkg::CMD_WR_IN && acc == 4'h0)) |=>
        r.in_regs[0] == $past(word) && $stable(r.out_regs))
        else $error("input write wrong");
    a_update_all: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (s_ack_end ##0 (cmd == odc_pkg::CMD_WR_UPD_ALL)) |=> r.out_regs == r.in_regs)
        else $error("global update wrong");
    a_update_ch: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (s_ack_end ##0 (cmd == odc_pkg::CMD_WR_UPD_CH && !acc[3])) |=>
        r.out_regs[$past(acc[2:0])] == $past(word))
        else $error("channel update wrong");
    a_power_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (s_ack_end ##0 (cmd == odc_pkg::CMD_POWER)) |=> o_power_ctrl == $past(word))
        else $error("power write wrong");
    a_update_timing: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (r.state == ST_ACK && !scl_fall) |=> $stable(r.out_regs))
        else $error("update before ack end");
    a_cmd_kept: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (r.byte_idx >= 2'h2 && r.state != ST_IDLE) |=> $stable(r.command_access_byte))
        else $error("command lost");
    a_copy_select: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (s_ack_end ##0 (cmd == odc_pkg::CMD_UPD_CH && !acc[3])) |=>
        r.out_regs[$past(acc[2:0])] == $past(r.in_regs[acc[2:0]]))
        else $error("channel copy wrong");
    a_sw_reset_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (s_ack_end ##0 (cmd == odc_pkg::CMD_SW_RESET)) |=>
        o_sw_reset && o_power_ctrl == odc_pkg::REG_RESET && r.out_regs == '0)
        else $error("software reset incomplete");
    a_read_first_bit: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (r.state == ST_ACK && scl_fall && r.byte_idx == 2'h0 && r.rd) |=>
        r.state == ST_TX && r.sda_oe == !$past(r.tx_word[15]))
        else $error("read high bit wrong");
endmodule

/* logic/odc_pkg.sv */
package odc_pkg;
    localparam logic [3:0] ADDR_PREFIX = 4'h9;
    localparam logic [3:0] CMD_WR_IN = 4'h0;
    localparam logic [3:0] CMD_UPD_CH = 4'h1;
    localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
    localparam logic [3:0] CMD_WR_UPD_CH = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_CLEAR = 4'h5;
    localparam logic [3:0] CMD_LOAD_MASK = 4'h6;
    localparam logic [3:0] CMD_SW_RESET = 4'h7;
    localparam logic [3:0] ACC_ALL = 4'hF;
    localparam int NUM_CH = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // strap levels
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_HIGH = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
    // bit positions
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 4;
    localparam int ACC_MSB = 3;
    localparam int ACC_LSB = 0;
endpackage

/* logic/odc_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin inputs
module odc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,               // system clock
    input wire logic i_sys_rst,            // sync reset, high
    input wire logic i_rst_val,            // value held in reset
    input wire logic [WIDTH-1:0] i_async,  // asynchronous input
    output logic [WIDTH-1:0] o_sync        // synchronised output
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } odc_sync_t;
    odc_sync_t st;
    odc_sync_t next_st;
    always_comb begin
        next_st.stage1 = i_async;
        next_st.stage2 = st.stage1;
        if (i_sys_rst) begin
            next_st.stage1 = {WIDTH{i_rst_val}};
            next_st.stage2 = {WIDTH{i_rst_val}};
        end
    end
    always_ff @(posedge i_mclk) begin
        st <= next_st;
    end
    assign o_sync = st.stage2;
endmodule

/* logic/odc_strap_decode.sv */
`timescale 1ns/1ps
// three-level strap pair to low address bits
module odc_strap_decode (
    input wire logic i_two_strap,          // two-strap variant select
    input wire logic [1:0] i_upper,        // strap_pin_upper level
    input wire logic [1:0] i_lower,        // strap_pin_lower level
    output logic [2:0] o_low_bits          // slave address bits 2:0
);
    always_comb begin
        o_low_bits = 3'h0;
        if (!i_two_strap) begin
            unique case (i_lower)
                odc_pkg::STRAP_HIGH: o_low_bits = 3'h2;
                odc_pkg::STRAP_FLOAT: o_low_bits = 3'h4;
                default: o_low_bits = 3'h0;
            endcase
        end else if (i_upper == odc_pkg::STRAP_FLOAT) begin
            o_low_bits = (i_lower == odc_pkg::STRAP_HIGH) ? 3'h5 : 3'h4;
        end else if (i_lower == odc_pkg::STRAP_FLOAT) begin
            o_low_bits = (i_upper == odc_pkg::STRAP_HIGH) ? 3'h7 : 3'h6;
        end else begin
            o_low_bits = {1'b0, i_upper == odc_pkg::STRAP_HIGH, i_lower == odc_pkg::STRAP_HIGH};
        end
    end
endmodule

/* bench/odc_master_model.sv */
`timescale 1ns/1ps
// bus master: open-drain clock and data, 125 ns bit time
module odc_master_model (
    input wire logic i_sda,  // resolved data line
    output logic o_scl_oe,   // pull clock low while high
    output logic o_sda_oe    // pull data low while high
);
    localparam realtime QTR = 31.25;
    // idle: both lines released to the pull-ups, clock stands still
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end
    task automatic start_cond();
        #(QTR * 2);
        o_sda_oe = 1'b1;
        #(QTR * 2);
        o_scl_oe = 1'b1;
    endtask
    task automatic rstart_cond();
        #QTR;
        o_sda_oe = 1'b0;
        #QTR;
        o_scl_oe = 1'b0;
        #(QTR * 2);
        o_sda_oe = 1'b1;
        #(QTR * 2);
        o_scl_oe = 1'b1;
    endtask
    task automatic stop_cond();
        #QTR;
        o_sda_oe = 1'b1;
        #QTR;
        o_scl_oe = 1'b0;
        #(QTR * 2);
        o_sda_oe = 1'b0;
        #(QTR * 2);
    endtask
    // data set mid-low, sampled mid-high
    task automatic send_bit(input logic b, output logic seen);
        #QTR;
        o_sda_oe = ~b;
        #QTR;
        o_scl_oe = 1'b0;
        #QTR;
        seen = i_sda;
        #QTR;
        o_scl_oe = 1'b1;
    endtask
    task automatic write_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], s);
        end
        send_bit(1'b1, s);
        acked = ~s;
    endtask
    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'b1, s);
            b[i] = s;
        end
        send_bit(~ack, s);
    endtask
endmodule

/* bench/odc_decoder_test.sv */
`timescale 1ns/1ps
module odc_decoder_test;
    logic mclk;
    logic sys_rst;
    logic two_strap;
    logic [1:0] strap_up;
    logic [1:0] strap_lo;
    logic m_scl_oe;
    logic m_sda_oe;
    logic d_sda_oe;
    logic d_sda_out;
    logic scl;
    logic sda;
    logic [127:0] out_regs;
    logic [15:0] power_ctrl;
    logic [15:0] clear_code;
    logic [15:0] load_mask;
    logic sw_reset;
    logic [6:0] dev;
    logic [15:0] exp_out [8];
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int resets_seen = 0;
    assign scl = ~m_scl_oe;
    assign sda = ~(m_sda_oe | (d_sda_oe & ~d_sda_out));
    odc_decoder #(.NUM_CH(odc_pkg::NUM_CH)) odc_decoder_i (
        .i_mclk(mclk), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
        .o_sda_oe(d_sda_oe), .o_sda_out(d_sda_out), .i_two_strap(two_strap),
        .i_strap_pin_upper(strap_up), .i_strap_pin_lower(strap_lo),
        .o_out_regs(out_regs), .o_power_ctrl(power_ctrl), .o_clear_code(clear_code),
        .o_load_mask(load_mask), .o_sw_reset(sw_reset)
    );
    odc_master_model odc_master_model_i (.i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (sw_reset === 1'b1) resets_seen++;
        if (cycles == 50000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] expected);
        total_checks++;
        if (seen !== expected) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expected);
        end
    endtask
    function automatic logic [127:0] pack_out();
        logic [127:0] v;
        for (int i = 0; i < 8; i++) v[i*16 +: 16] = exp_out[i];
        return v;
    endfunction
    task automatic set_straps(input logic two, input logic [1:0] up, input logic [1:0] lo);
        @(posedge mclk);
        #1;
        two_strap = two;
        strap_up = up;
        strap_lo = lo;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic probe(input logic [6:0] a, output logic acked);
        odc_master_model_i.start_cond();
        odc_master_model_i.write_byte({a, 1'b0}, acked);
        odc_master_model_i.stop_cond();
        repeat (8) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [15:0] word);
        logic a0, a1, a2, a3;
        odc_master_model_i.start_cond();
        odc_master_model_i.write_byte({dev, 1'b0}, a0);
        odc_master_model_i.write_byte(cmd, a1);
        odc_master_model_i.write_byte(word[15:8], a2);
        odc_master_model_i.write_byte(word[7:0], a3);
        odc_master_model_i.stop_cond();
        repeat (8) @(posedge mclk);
        #1;
        check(128'(a0 & a1 & a2 & a3), 128'h1);
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [15:0] word);
        logic a0, a1, a2;
        logic [7:0] hi, lo;
        odc_master_model_i.start_cond();
        odc_master_model_i.write_byte({dev, 1'b0}, a0);
        odc_master_model_i.write_byte(cmd, a1);
        odc_master_model_i.rstart_cond();
        odc_master_model_i.write_byte({dev, 1'b1}, a2);
        odc_master_model_i.read_byte(1'b1, hi);
        odc_master_model_i.read_byte(1'b0, lo);
        odc_master_model_i.stop_cond();
        repeat (8) @(posedge mclk);
        #1;
        word = {hi, lo};
        check(128'(a0 & a1 & a2), 128'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_address();
        logic [1:0] up_t [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1};
        logic [1:0] lo_t [8] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
        logic ack;
        for (int i = 0; i < 8; i++) begin
            set_straps(1'b1, up_t[i], lo_t[i]);
            probe({odc_pkg::ADDR_PREFIX, 3'(i)}, ack);
            check(128'(ack), 128'h1);
            probe({odc_pkg::ADDR_PREFIX, 3'(i) ^ 3'h1}, ack);
            check(128'(ack), 128'h0);
            probe({4'h8, 3'(i)}, ack);
            check(128'(ack), 128'h0);
        end
        for (int i = 0; i < 3; i++) begin
            set_straps(1'b0, 2'h2, 2'(i));
            probe({odc_pkg::ADDR_PREFIX, 3'(i * 2)}, ack);
            check(128'(ack), 128'h1);
        end
        set_straps(1'b1, 2'h1, 2'h0);
        dev = 7'h4A;
    endtask
    task automatic t_channel();
        logic [15:0] w;
        wr(8'h01, 16'h1234);
        check(out_regs, pack_out());
        rd(8'h01, w);
        check(128'(w), 128'h1234);
        wr(8'h11, 16'h0000);
        exp_out[1] = 16'h1234;
        check(out_regs, pack_out());
        rd(8'h11, w);
        check(128'(w), 128'h1234);
    endtask
    task automatic t_same_cmd();
        logic a;
        odc_master_model_i.start_cond();
        odc_master_model_i.write_byte({dev, 1'b0}, a);
        odc_master_model_i.write_byte(8'h37, a);
        odc_master_model_i.write_byte(8'hAB, a);
        repeat (8) @(posedge mclk);
        #1;
        check(out_regs, pack_out());
        odc_master_model_i.write_byte(8'hCD, a);
        repeat (8) @(posedge mclk);
        #1;
        exp_out[7] = 16'hABCD;
        check(out_regs, pack_out());
        odc_master_model_i.write_byte(8'h55, a);
        odc_master_model_i.write_byte(8'hAA, a);
        odc_master_model_i.stop_cond();
        repeat (8) @(posedge mclk);
        #1;
        exp_out[7] = 16'h55AA;
        check(out_regs, pack_out());
    endtask
    task automatic t_all();
        wr(8'h00, 16'h1111);
        wr(8'h24, 16'h2222);
        exp_out[0] = 16'h1111;
        exp_out[4] = 16'h2222;
        check(out_regs, pack_out());
        wr(8'h0F, 16'h0F0F);
        wr(8'h1F, 16'h0000);
        for (int i = 0; i < 8; i++) exp_out[i] = 16'h0F0F;
        check(out_regs, pack_out());
    endtask
    task automatic t_misc();
        logic [15:0] w;
        wr(8'h4A, 16'h0003);
        wr(8'h5C, 16'h8001);
        wr(8'h63, 16'h00FF);
        check(128'({power_ctrl, clear_code, load_mask}), 128'h0003_8001_00FF);
        rd(8'h47, w);
        check(128'(w), 128'h0003);
        rd(8'h51, w);
        check(128'(w), 128'h8001);
        rd(8'h6E, w);
        check(128'(w), 128'h00FF);
        wr(8'h75, 16'h0000);
        check(128'(resets_seen), 128'h1);
        check(128'({out_regs, power_ctrl, clear_code, load_mask} != '0), 128'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        two_strap = 1'b1;
        strap_up = 2'h0;
        strap_lo = 2'h0;
        dev = 7'h48;
        for (int i = 0; i < 8; i++) exp_out[i] = 16'h0000;
        repeat (16) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge mclk);
        t_address();
        t_channel();
        t_same_cmd();
        t_all();
        t_misc();
        tally_and_finish();
    end
endmodule
